// [core/dbg_map.svh]
`ifndef DBG_MAP_SVH
`define DBG_MAP_SVH

// Oscillator edges per processor clock, counted 0..2
`define DBG_DIV_LAST 2'h2
`define DBG_DIV_FIRST 2'h0

// Address field positions on the 20-bit local address
`define DBG_ADDR_W 20
`define DBG_MSEL_HI 19
`define DBG_MSEL_LO 18
`define DBG_UPPER_HI 19
`define DBG_UPPER_LO 16
`define DBG_MID_HI 15
`define DBG_MID_LO 8
`define DBG_LOW_HI 7
`define DBG_LOW_LO 0
`define DBG_IOSEL_HI 7
`define DBG_IOSEL_LO 5

// Memory map
`define DBG_MSEL_RAM 2'h0
`define DBG_MSEL_ROM 2'h3
`define DBG_ROM_BASE 20'hF8000
`define DBG_RAM_TOP 20'h007FF
`define DBG_RESET_VEC 20'hFFFF0
`define DBG_UPPER_IO 4'h0

// I/O select decoder codes on A7..A5
`define DBG_IO_HOST 3'h0
`define DBG_IO_IRQC 3'h1
`define DBG_IO_DMA 3'h2
`define DBG_IO_DISC 3'h3
`define DBG_IO_LATCH 3'h4

// Reset values
`define DBG_BYTE_ZERO 8'h00
`define DBG_ADDR_ZERO 20'h00000
`define DBG_TCNT_ZERO 3'h0
`define DBG_TCNT_ONE 3'h1
`define DBG_TCNT_MIN 3'h3
`define DBG_TCNT_MAX 3'h7

`endif

// [core/dbg_pkg.sv]
package dbg_pkg;

   typedef enum logic [2:0] {
      DBG_ST_IDLE,
      DBG_ST_T1,
      DBG_ST_T2,
      DBG_ST_T3,
      DBG_ST_TW,
      DBG_ST_T4,
      DBG_ST_HOLD
   } dbg_state_t;

endpackage : dbg_pkg

// [core/dbg_pin_sync.sv]
`timescale 1ns/10ps

module dbg_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Asynchronous pins and their settled levels
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] agree_w;

   // A bit moves only once the second and third stage agree
   assign agree_w = ~(s2_r ^ s3_r);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s1_r <= RST;
         s2_r <= RST;
         s3_r <= RST;
         level_o <= RST;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         level_o <= (agree_w & s3_r) | (~agree_w & level_o);
      end
   end

endmodule : dbg_pin_sync

// [core/dbg_clk_div.sv]
`timescale 1ns/10ps
`include "dbg_map.svh"

module dbg_clk_div (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Settled oscillator level
   input wire logic osc_lvl_i,
   // Derived clocks and phase enables
   output logic osc_out_o,
   output logic cpu_clk_o,
   output logic rise_o,
   output logic fall_o
);

   logic osc_prev_r;
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic osc_edge_w;

   assign osc_edge_w = osc_lvl_i & ~osc_prev_r;
   assign cnt_nxt = (cnt_r == `DBG_DIV_LAST) ? `DBG_DIV_FIRST : cnt_r + 2'h1;
   // Processor clock is high for one oscillator period in three
   assign rise_o = osc_edge_w & (cnt_r == `DBG_DIV_LAST);
   assign fall_o = osc_edge_w & (cnt_r == `DBG_DIV_FIRST);
   assign osc_out_o = osc_prev_r;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         osc_prev_r <= 1'b0;
         cnt_r <= `DBG_DIV_FIRST;
         cpu_clk_o <= 1'b0;
      end else begin
         osc_prev_r <= osc_lvl_i;
         if (osc_edge_w) begin
            cnt_r <= cnt_nxt;
         end
         if (rise_o) begin
            cpu_clk_o <= 1'b1;
         end else if (fall_o) begin
            cpu_clk_o <= 1'b0;
         end
      end
   end

endmodule : dbg_clk_div

// [core/dbg_glue.sv]
`timescale 1ns/10ps
`include "dbg_map.svh"

// What this block does
// - Each bus transfer lasts at least four processor clocks, T1 to T4.
// - A read opens in T1 with the address strobe; low byte latched at its end.
// - The memory or I/O indicator stays valid from T1 through T4.
// - In T2 the address leaves the shared bus, then read strobe goes low.
// - Reads of main system memory also turn on the data transceiver.
// - Write strobe asserts at T2 start; write data driven T2 until T4.
// - Top four address lines are low in I/O cycles; 64k I/O space.
// - Processor clock is the 15 MHz oscillator divided by three.
// - Ready request is synchronised on the clock fall; low ready adds waits.
// - Low address byte latched on address strobe fall while release ack low.
// - Latched low byte and middle byte are driven onto the system bus.
// - Transceiver passes toward the system when direction is high.
// - Read and write strobes split into I/O and memory strobes when owning bus.
// - Top two address bits and the RAM/ROM ranges pick RAM, ROM or system bus, latched at address strobe fall, gated by bus ownership.
// - ROM spans F8000H to FFFFFH; first fetch after reset is FFFF0H.
// - RAM spans 00000H to 007FFH.
// - I/O selects decode address bits 7..5 in I/O cycles while owning bus.
// - I/O range 00-1FH selects the lowest output, interrupting the host.
// - I/O ranges pick interrupt, DMA, disc controller and drive latch.
// - A DMA takeover request floats the buses, then release ack rises.
// - System memory needs a bus request and a low grant before transfer.

module dbg_glue (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Clock generator pins
   input wire logic osc_15m_i,
   input wire logic ready_req_i,
   input wire logic ready_sync_mode_n_i,
   input wire logic power_on_rc_n_i,
   output logic osc_out_o,
   output logic cpu_clk_o,
   output logic cpu_reset_o,
   output logic ready_o,
   // Transfer requests
   input wire logic req_i,
   input wire logic req_write_i,
   input wire logic req_io_i,
   input wire logic [19:0] req_addr_i,
   input wire logic [7:0] req_wdata_i,
   output logic req_ready_o,
   output logic done_o,
   output logic [7:0] rdata_o,
   // Local multiplexed bus
   input wire logic [7:0] lad_i,
   output logic [7:0] lad_o,
   output logic lad_oe_n_o,
   output logic [11:0] laddr_hi_o,
   output logic laddr_hi_oe_n_o,
   output logic ale_o,
   output logic mem_io_o,
   output logic rd_n_o,
   output logic wr_n_o,
   // Split strobes
   output logic io_read_n_o,
   output logic io_write_n_o,
   output logic mem_read_n_o,
   output logic mem_write_n_o,
   // Chip selects
   output logic rom_select_n_o,
   output logic ram_select_n_o,
   output logic host_irq_select_n_o,
   output logic irq_ctrl_select_n_o,
   output logic dma_select_n_o,
   output logic disc_ctrl_select_n_o,
   output logic drive_latch_select_n_o,
   output logic disc_board_irq_n_o,
   // System bus
   input wire logic sysbus_grant_n_i,
   input wire logic [7:0] sys_ad_i,
   output logic sysbus_request_n_o,
   output logic [7:0] sys_ad_o,
   output logic sys_ad_oe_n_o,
   output logic [7:0] sys_addr_hi_o,
   output logic xcvr_enable_n_o,
   output logic xcvr_direction_o,
   // Bus takeover
   input wire logic hold_i,
   output logic bus_release_ack_o
);

   function automatic logic [4:0] io_decode(input logic [2:0] code, input logic en);
      logic [4:0] sel;
      sel = 5'h1F;
      if (en) begin
         sel[0] = (code != `DBG_IO_HOST);
         sel[1] = (code != `DBG_IO_IRQC);
         sel[2] = (code != `DBG_IO_DMA);
         sel[3] = (code != `DBG_IO_DISC);
         sel[4] = (code != `DBG_IO_LATCH);
      end
      return sel;
   endfunction : io_decode

   // Settled pin levels
   logic osc_s;
   logic ready_s;
   logic rc_n_s;
   logic hold_s;
   logic grant_n_s;
   logic rise_w;
   logic fall_w;

   dbg_pin_sync #(.W(5), .RST(5'h18)) u_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .pin_i({power_on_rc_n_i, sysbus_grant_n_i, hold_i, ready_req_i, osc_15m_i}),
      .level_o({rc_n_s, grant_n_s, hold_s, ready_s, osc_s})
   );

   dbg_clk_div u_div (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .osc_lvl_i(osc_s),
      .osc_out_o(osc_out_o),
      .cpu_clk_o(cpu_clk_o),
      .rise_o(rise_w),
      .fall_o(fall_w)
   );

   dbg_pkg::dbg_state_t st_r;
   dbg_pkg::dbg_state_t st_nxt;
   logic rst_w;
   logic ready_pre_r;
   logic pend_r;
   logic boot_pend_r;
   logic [19:0] cyc_addr_r;
   logic cyc_wr_r;
   logic cyc_io_r;
   logic [7:0] wdata_r;
   logic [7:0] lat_addr_r;
   logic ack_r;
   logic ram_r;
   logic rom_r;
   logic sys_r;
   logic sys_go_r;
   logic [2:0] tcnt_r;
   logic take_w;
   logic cyc_ready_w;
   logic in_cycle_w;
   logic owner_w;
   logic xcvr_on_w;
   logic [1:0] msel_w;
   logic ram_hit_w;
   logic rom_hit_w;
   logic [4:0] io_sel_w;

   // The RC pin holds request capture and the sequencer in reset until its level has settled high and the processor clock falls
   assign rst_w = srst_i | cpu_reset_o;
   assign owner_w = ~ack_r;
   assign in_cycle_w = (st_r != dbg_pkg::DBG_ST_IDLE) && (st_r != dbg_pkg::DBG_ST_HOLD);
   assign take_w = req_i & req_ready_o;
   assign req_ready_o = (st_r == dbg_pkg::DBG_ST_IDLE) & ~pend_r & ~boot_pend_r & ~hold_s
      & ~rst_w;
   // A system cycle finishes one processor clock past the grant: that clock has the transceiver on
   assign cyc_ready_w = ready_o & (~sys_r | sys_go_r);

   assign msel_w = cyc_addr_r[`DBG_MSEL_HI:`DBG_MSEL_LO];
   // Decoding is narrower than the top bits: holes inside 00 and 11 go to the system bus
   assign ram_hit_w = (msel_w == `DBG_MSEL_RAM) && (cyc_addr_r <= `DBG_RAM_TOP);
   assign rom_hit_w = (msel_w == `DBG_MSEL_ROM) && (cyc_addr_r >= `DBG_ROM_BASE);

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         dbg_pkg::DBG_ST_IDLE: begin
            if (hold_s) begin
               st_nxt = dbg_pkg::DBG_ST_HOLD;
            end else if (pend_r) begin
               st_nxt = dbg_pkg::DBG_ST_T1;
            end
         end
         dbg_pkg::DBG_ST_T1: st_nxt = dbg_pkg::DBG_ST_T2;
         dbg_pkg::DBG_ST_T2: st_nxt = dbg_pkg::DBG_ST_T3;
         dbg_pkg::DBG_ST_T3, dbg_pkg::DBG_ST_TW: begin
            st_nxt = cyc_ready_w ? dbg_pkg::DBG_ST_T4 : dbg_pkg::DBG_ST_TW;
         end
         dbg_pkg::DBG_ST_T4: st_nxt = dbg_pkg::DBG_ST_IDLE;
         dbg_pkg::DBG_ST_HOLD: begin
            // Leaving on a short takeover too, so a dropped request cannot lock the engine
            if (!hold_s) begin
               st_nxt = dbg_pkg::DBG_ST_IDLE;
            end
         end
         default: st_nxt = dbg_pkg::DBG_ST_IDLE;
      endcase
   end

   // Processor reset and ready synchroniser
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cpu_reset_o <= 1'b1;
         ready_pre_r <= 1'b0;
         ready_o <= 1'b0;
      end else begin
         if (!rc_n_s) begin
            cpu_reset_o <= 1'b1;
         end else if (fall_w) begin
            cpu_reset_o <= 1'b0;
         end
         if (rise_w) begin
            ready_pre_r <= ready_s;
         end
         if (fall_w) begin
            ready_o <= ready_sync_mode_n_i ? ready_s : ready_pre_r;
         end
      end
   end

   // Request capture and the opening fetch from the reset vector
   always_ff @(posedge clk_i) begin
      if (rst_w) begin
         pend_r <= 1'b0;
         boot_pend_r <= 1'b1;
         cyc_addr_r <= `DBG_RESET_VEC;
         cyc_wr_r <= 1'b0;
         cyc_io_r <= 1'b0;
         wdata_r <= `DBG_BYTE_ZERO;
      end else if (boot_pend_r && st_r == dbg_pkg::DBG_ST_IDLE) begin
         boot_pend_r <= 1'b0;
         pend_r <= 1'b1;
      end else if (take_w) begin
         pend_r <= 1'b1;
         cyc_addr_r <= req_addr_i;
         cyc_wr_r <= req_write_i;
         cyc_io_r <= req_io_i;
         wdata_r <= req_wdata_i;
      end else if (rise_w && st_r == dbg_pkg::DBG_ST_IDLE && !hold_s) begin
         pend_r <= 1'b0;
      end
   end

   // Bus cycle sequencer
   always_ff @(posedge clk_i) begin
      if (rst_w) begin
         st_r <= dbg_pkg::DBG_ST_IDLE;
         ale_o <= 1'b0;
         lad_o <= `DBG_BYTE_ZERO;
         lad_oe_n_o <= 1'b1;
         laddr_hi_oe_n_o <= 1'b1;
         rd_n_o <= 1'b1;
         wr_n_o <= 1'b1;
         lat_addr_r <= `DBG_BYTE_ZERO;
         ram_r <= 1'b0;
         rom_r <= 1'b0;
         sys_r <= 1'b0;
         ack_r <= 1'b0;
         sys_go_r <= 1'b0;
         rdata_o <= `DBG_BYTE_ZERO;
         done_o <= 1'b0;
         tcnt_r <= `DBG_TCNT_ZERO;
      end else begin
         done_o <= 1'b0;
         if (rise_w) begin
            st_r <= st_nxt;
            if (in_cycle_w && tcnt_r != `DBG_TCNT_MAX) begin
               tcnt_r <= tcnt_r + `DBG_TCNT_ONE;
            end
            if (st_nxt == dbg_pkg::DBG_ST_T1 && st_r == dbg_pkg::DBG_ST_IDLE) begin
               ale_o <= 1'b1;
               lad_o <= cyc_addr_r[`DBG_LOW_HI:`DBG_LOW_LO];
               lad_oe_n_o <= 1'b0;
               laddr_hi_oe_n_o <= 1'b0;
               tcnt_r <= `DBG_TCNT_ZERO;
            end
            if (st_r == dbg_pkg::DBG_ST_T1) begin
               if (cyc_wr_r) begin
                  wr_n_o <= 1'b0;
                  lad_o <= wdata_r;
               end else begin
                  lad_oe_n_o <= 1'b1;
               end
            end
            if (st_nxt == dbg_pkg::DBG_ST_T4 && st_r != dbg_pkg::DBG_ST_T4) begin
               rd_n_o <= 1'b1;
               wr_n_o <= 1'b1;
               done_o <= 1'b1;
               // Read data are taken as the strobe rises, while the device still drives
               if (!cyc_wr_r) begin
                  rdata_o <= sys_r ? sys_ad_i : lad_i;
               end
            end
            if (sys_r && owner_w && !grant_n_s) begin
               sys_go_r <= 1'b1;
            end
            if (st_r == dbg_pkg::DBG_ST_T4) begin
               sys_go_r <= 1'b0;
               lad_oe_n_o <= 1'b1;
               laddr_hi_oe_n_o <= 1'b1;
               ram_r <= 1'b0;
               rom_r <= 1'b0;
               sys_r <= 1'b0;
            end
            // Release ack only rises a full clock after the buses were floated
            if (st_r == dbg_pkg::DBG_ST_HOLD) begin
               ack_r <= hold_s;
            end
         end
         if (fall_w && st_r == dbg_pkg::DBG_ST_T1 && ale_o) begin
            ale_o <= 1'b0;
            if (owner_w) begin
               lat_addr_r <= cyc_addr_r[`DBG_LOW_HI:`DBG_LOW_LO];
               ram_r <= ~cyc_io_r & ram_hit_w;
               rom_r <= ~cyc_io_r & rom_hit_w;
               sys_r <= ~cyc_io_r & ~ram_hit_w & ~rom_hit_w;
            end
         end
         if (fall_w && st_r == dbg_pkg::DBG_ST_T2 && !cyc_wr_r) begin
            rd_n_o <= 1'b0;
         end
      end
   end

   assign bus_release_ack_o = ack_r;
   assign mem_io_o = cyc_io_r;
   assign laddr_hi_o[11:8] = cyc_io_r ? `DBG_UPPER_IO
      : cyc_addr_r[`DBG_UPPER_HI:`DBG_UPPER_LO];
   assign laddr_hi_o[7:0] = cyc_addr_r[`DBG_MID_HI:`DBG_MID_LO];

   // Split strobes
   assign io_read_n_o = ~(owner_w & cyc_io_r & ~rd_n_o);
   assign io_write_n_o = ~(owner_w & cyc_io_r & ~wr_n_o);
   assign mem_read_n_o = ~(owner_w & ~cyc_io_r & ~rd_n_o);
   assign mem_write_n_o = ~(owner_w & ~cyc_io_r & ~wr_n_o);

   // Chip selects
   assign ram_select_n_o = ~(ram_r & owner_w);
   assign rom_select_n_o = ~(rom_r & owner_w);
   assign io_sel_w = io_decode(cyc_addr_r[`DBG_IOSEL_HI:`DBG_IOSEL_LO],
      owner_w & cyc_io_r & in_cycle_w);
   assign host_irq_select_n_o = io_sel_w[0];
   assign irq_ctrl_select_n_o = io_sel_w[1];
   assign dma_select_n_o = io_sel_w[2];
   assign disc_ctrl_select_n_o = io_sel_w[3];
   assign drive_latch_select_n_o = io_sel_w[4];
   assign disc_board_irq_n_o = host_irq_select_n_o | (io_read_n_o & io_write_n_o);

   // System bus side
   assign sysbus_request_n_o = ~(sys_r & owner_w);
   assign xcvr_on_w = sys_r & sys_go_r & owner_w & ~grant_n_s & (st_r != dbg_pkg::DBG_ST_T1)
      & in_cycle_w;
   assign xcvr_enable_n_o = ~xcvr_on_w;
   assign xcvr_direction_o = sys_r & cyc_wr_r;
   assign sys_ad_oe_n_o = ~(sys_r & owner_w & ~grant_n_s & (xcvr_direction_o | ~xcvr_on_w));
   assign sys_ad_o = (xcvr_on_w & xcvr_direction_o) ? lad_o : lat_addr_r;
   assign sys_addr_hi_o = cyc_addr_r[`DBG_MID_HI:`DBG_MID_LO];

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_w);

   a_ale_in_t1:
      assert property (ale_o |-> st_r == dbg_pkg::DBG_ST_T1)
      else $error("address strobe outside T1");

   a_latch_at_fall:
      assert property ($fell(ale_o) && owner_w |-> lat_addr_r == cyc_addr_r[7:0])
      else $error("low address byte not latched at strobe fall");

   a_upper_io_low:
      assert property (cyc_io_r && !laddr_hi_oe_n_o |-> laddr_hi_o[11:8] == 4'h0)
      else $error("upper address lines not low in I/O cycle");

   a_read_floats:
      assert property (st_r == dbg_pkg::DBG_ST_T2 && !cyc_wr_r |-> lad_oe_n_o && !ale_o)
      else $error("address still driven during read T2");

   a_write_strobe:
      assert property (st_r == dbg_pkg::DBG_ST_T2 && cyc_wr_r |-> !wr_n_o && !lad_oe_n_o
         && lad_o == wdata_r)
      else $error("write strobe or data missing in T2");

   a_hold_quiet:
      assert property (ack_r |-> ram_select_n_o && rom_select_n_o && dma_select_n_o
         && io_read_n_o && mem_write_n_o && sysbus_request_n_o)
      else $error("select or strobe active during takeover");

   a_ack_after_float:
      assert property ($rose(ack_r) |-> lad_oe_n_o && laddr_hi_oe_n_o
         && $past(st_r) == dbg_pkg::DBG_ST_HOLD)
      else $error("release ack before buses floated");

   a_wait_grant:
      assert property (st_r == dbg_pkg::DBG_ST_T3 && sys_r && grant_n_s && rise_w
         |=> st_r == dbg_pkg::DBG_ST_TW)
      else $error("system transfer went ahead without grant");

   a_ready_wait:
      assert property (st_r == dbg_pkg::DBG_ST_T3 && !ready_o && rise_w
         |=> st_r == dbg_pkg::DBG_ST_TW)
      else $error("no wait state while ready low");

   a_cycle_length:
      assert property (done_o |-> tcnt_r >= `DBG_TCNT_MIN)
      else $error("bus cycle shorter than four clocks");

   a_dma_range:
      assert property (!dma_select_n_o |-> cyc_io_r && cyc_addr_r[7:5] == 3'h2)
      else $error("DMA select outside 40-5FH");

   a_xcvr_dir:
      assert property (!xcvr_enable_n_o |-> xcvr_direction_o == cyc_wr_r)
      else $error("transceiver direction wrong");

endmodule : dbg_glue

// [dv/dbg_far_model.sv]
`timescale 1ns/10ps

module dbg_far_model #(
   parameter int GRANT_DLY = 40
) (
   // Clock
   input wire logic clk_i,
   // Local bus as seen by the addressed devices
   input wire logic ale_i,
   input wire logic rd_n_i,
   input wire logic [7:0] bus_i,
   output logic [7:0] local_data_o,
   // System side
   input wire logic sysbus_request_n_i,
   input wire logic xcvr_enable_n_i,
   input wire logic xcvr_direction_i,
   output logic [7:0] sys_data_o,
   output logic sysbus_grant_n_o
);
   logic [7:0] addr_r = 8'h00;
   logic [7:0] loc_r = 8'h00;
   logic [7:0] sys_r = 8'h00;
   logic grant_n_r = 1'b1;
   int wait_r = 0;

   assign local_data_o = loc_r;
   assign sys_data_o = sys_r;
   assign sysbus_grant_n_o = grant_n_r;

   always_ff @(posedge clk_i) begin
      if (ale_i) begin
         addr_r <= bus_i;
      end
      // Released lines toggle so a stale value never reads as good data
      loc_r <= !rd_n_i ? (addr_r ^ 8'hA5) : ~loc_r;
      sys_r <= (!xcvr_enable_n_i && !xcvr_direction_i) ? (addr_r ^ 8'h3C) : ~sys_r;
      if (sysbus_request_n_i) begin
         wait_r <= 0;
         grant_n_r <= 1'b1;
      end else if (wait_r == GRANT_DLY) begin
         grant_n_r <= 1'b0;
      end else begin
         wait_r <= wait_r + 1;
      end
   end
endmodule : dbg_far_model

// [dv/testbench.sv]
`timescale 1ns/10ps
`define CHECK_EQ(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
   $display("Error %0t: mismatch got %h exp %h", $time, (a), (b)); end end

module testbench;
   logic clk_i = 0, srst_i = 1, osc_15m_i = 0, ready_req_i = 1, power_on_rc_n_i = 0;
   logic req_i = 0, req_write_i = 0, req_io_i = 0, hold_i = 0, ready_sync_mode_n_i = 1;
   logic [19:0] req_addr_i = 20'h00000;
   logic [7:0] req_wdata_i = 8'h00;
   logic osc_out_o, cpu_clk_o, cpu_reset_o, ready_o, req_ready_o, done_o;
   logic lad_oe_n_o, laddr_hi_oe_n_o, ale_o, mem_io_o, rd_n_o, wr_n_o, irq_n;
   logic sysbus_grant_n_i, sysbus_request_n_o, sys_ad_oe_n_o;
   logic xcvr_enable_n_o, xcvr_direction_o, bus_release_ack_o;
   logic [7:0] rdata_o, lad_o, lad_i, sys_ad_i, sys_ad_o, sys_addr_hi_o, lo_at;
   logic [11:0] laddr_hi_o, hi_at;
   logic [3:0] strb, strb_seen;
   logic [6:0] sel, sel_seen;
   logic irq_seen, sysbus_request_n_seen, xen_seen, dir_seen, wd_ok, mio_ok, mio_at, float_ok;
   logic sys_lo_seen, hi_ok;
   int error_cnt = 0, n_compared = 0, cycles = 0, dur = 0;

   dbg_glue dut (
      .clk_i, .srst_i, .osc_15m_i, .ready_req_i, .ready_sync_mode_n_i,
      .power_on_rc_n_i, .osc_out_o, .cpu_clk_o, .cpu_reset_o, .ready_o,
      .req_i, .req_write_i, .req_io_i, .req_addr_i, .req_wdata_i, .req_ready_o,
      .done_o, .rdata_o, .lad_i, .lad_o, .lad_oe_n_o, .laddr_hi_o, .laddr_hi_oe_n_o,
      .ale_o, .mem_io_o, .rd_n_o, .wr_n_o, .io_read_n_o(strb[0]), .io_write_n_o(strb[1]),
      .mem_read_n_o(strb[2]), .mem_write_n_o(strb[3]), .rom_select_n_o(sel[0]),
      .ram_select_n_o(sel[1]), .host_irq_select_n_o(sel[2]), .irq_ctrl_select_n_o(sel[3]),
      .dma_select_n_o(sel[4]), .disc_ctrl_select_n_o(sel[5]),
      .drive_latch_select_n_o(sel[6]), .disc_board_irq_n_o(irq_n), .sysbus_grant_n_i,
      .sys_ad_i, .sysbus_request_n_o, .sys_ad_o, .sys_ad_oe_n_o, .sys_addr_hi_o,
      .xcvr_enable_n_o, .xcvr_direction_o, .hold_i, .bus_release_ack_o
   );

   // Grant comes late enough that an ungated cycle would reach T4 before it
   dbg_far_model #(.GRANT_DLY(120)) far (
      .clk_i, .ale_i(ale_o), .rd_n_i(rd_n_o), .bus_i(lad_o), .local_data_o(lad_i),
      .sysbus_request_n_i(sysbus_request_n_o), .xcvr_enable_n_i(xcvr_enable_n_o),
      .xcvr_direction_i(xcvr_direction_o), .sys_data_o(sys_ad_i),
      .sysbus_grant_n_o(sysbus_grant_n_i)
   );

   initial begin
      forever #4 clk_i = ~clk_i;
   end
   // Oscillator free-runs with no phase tie to the system clock
   initial begin
      forever #33.33 osc_15m_i = ~osc_15m_i;
   end

   task automatic wrap_up;
      $display("Compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         error_cnt++;
         $display("Error %0t: run did not finish", $time);
         wrap_up;
      end
   end

   // Follows one transfer to its end and gathers what the pins did
   task automatic watch(input int rel);
      sel_seen = 7'h7F; strb_seen = 4'hF; irq_seen = 1; sysbus_request_n_seen = 1; xen_seen = 1;
      dir_seen = 0; wd_ok = 1; mio_ok = 1; float_ok = 1; sys_lo_seen = 0; hi_ok = 1;
      dur = 0;
      while (dur < 3000 && done_o !== 1'b1) begin
         @(posedge clk_i); #1;
         dur++;
         if (dur == rel) ready_req_i = 1;
         if (ale_o) begin
            lo_at = lad_o; hi_at = laddr_hi_o; mio_at = mem_io_o;
         end
         sel_seen &= sel; strb_seen &= strb; irq_seen &= irq_n;
         sysbus_request_n_seen &= sysbus_request_n_o;
         if (!rd_n_o || !wr_n_o) mio_ok &= (mem_io_o === mio_at);
         if (!rd_n_o) float_ok &= (lad_oe_n_o === 1'b1);
         if (!wr_n_o) wd_ok &= (lad_o === req_wdata_i && lad_oe_n_o === 1'b0);
         if (!xcvr_enable_n_o) begin
            xen_seen = 0; dir_seen = xcvr_direction_o;
            hi_ok &= (sys_addr_hi_o === req_addr_i[15:8]);
         end
         if (!sys_ad_oe_n_o && sys_ad_o === req_addr_i[7:0]) sys_lo_seen = 1;
      end
      `CHECK_EQ(done_o, 1'b1)
   endtask : watch

   task automatic xfer(input logic w, io, input logic [19:0] a, input logic [7:0] d, input int rel);
      for (int n = 0; n < 500 && req_ready_o !== 1'b1; n++) begin
         @(posedge clk_i); #1;
      end
      req_i = 1; req_write_i = w; req_io_i = io; req_addr_i = a; req_wdata_i = d;
      if (rel > 0) ready_req_i = 0;
      @(posedge clk_i); #1;
      req_i = 0;
      watch(rel);
   endtask : xfer

   task automatic t_boot;
      watch(0);
      `CHECK_EQ(lo_at, 8'hF0)
      `CHECK_EQ(hi_at, 12'hFFF)
      `CHECK_EQ(sel_seen, 7'h7E)
      `CHECK_EQ(strb_seen, 4'hB)
      `CHECK_EQ(cpu_reset_o, 1'b0)
   endtask : t_boot

   task automatic t_clk;
      int n;
      int m;
      logic po;
      logic fell;
      @(posedge cpu_clk_o); #1;
      n = 0;
      m = 0;
      po = osc_out_o;
      fell = 0;
      while (!(fell && cpu_clk_o === 1'b1) && n < 100) begin
         @(posedge clk_i); #1;
         n++;
         if (cpu_clk_o === 1'b0) fell = 1;
         if (osc_out_o === 1'b1 && po === 1'b0) m++;
         po = osc_out_o;
      end
      `CHECK_EQ(n >= 24 && n <= 26, 1'b1)
      `CHECK_EQ(m, 3)
   endtask : t_clk

   task automatic t_ram_read;
      xfer(0, 0, 20'h007FF, 8'h00, 0);
      `CHECK_EQ(rdata_o, 8'h5A)
      `CHECK_EQ(sel_seen, 7'h7D)
      `CHECK_EQ(strb_seen, 4'hB)
      `CHECK_EQ(lo_at, 8'hFF)
      `CHECK_EQ({float_ok, mio_ok, xen_seen}, 3'h7)
      `CHECK_EQ(dur >= 70, 1'b1)
   endtask : t_ram_read

   task automatic t_io_writes;
      logic [2:0] k;
      for (int i = 0; i < 6; i++) begin
         k = i[2:0];
         xfer(1, 1, {4'hA, 8'h5C, k, 5'h1F}, 8'hC3 ^ {5'h00, k}, 0);
         `CHECK_EQ(hi_at, 12'h05C)
         `CHECK_EQ(sel_seen, (i < 5) ? ~(7'h04 << i) : 7'h7F)
         `CHECK_EQ(irq_seen, i != 0)
         `CHECK_EQ(strb_seen, 4'hD)
         `CHECK_EQ({wd_ok, mio_ok}, 2'h3)
      end
   endtask : t_io_writes

   task automatic t_sys;
      xfer(0, 0, 20'h45A12, 8'h00, 0);
      `CHECK_EQ(rdata_o, 8'h2E)
      `CHECK_EQ({sysbus_request_n_seen, xen_seen, dir_seen}, 3'h0)
      `CHECK_EQ({hi_ok, sys_lo_seen}, 2'h3)
      `CHECK_EQ(sel_seen, 7'h7F)
      `CHECK_EQ(dur >= 150, 1'b1)
      xfer(1, 0, 20'h87733, 8'h96, 0);
      `CHECK_EQ({dir_seen, wd_ok, xen_seen}, 3'h6)
   endtask : t_sys

   task automatic t_wait;
      // Both strap settings of the ready synchroniser
      for (int m = 0; m < 2; m++) begin
         ready_sync_mode_n_i = ~m[0];
         xfer(0, 0, 20'h00010, 8'h00, 300);
         `CHECK_EQ(dur >= 300, 1'b1)
         `CHECK_EQ(rdata_o, 8'hB5)
      end
      ready_sync_mode_n_i = 1'b1;
   endtask : t_wait

   task automatic t_hold;
      logic ok;
      hold_i = 1;
      for (int n = 0; n < 200 && bus_release_ack_o !== 1'b1; n++) begin
         @(posedge clk_i); #1;
      end
      `CHECK_EQ(bus_release_ack_o, 1'b1)
      ok = 1;
      repeat (40) begin
         @(posedge clk_i); #1;
         ok &= (sel === 7'h7F && strb === 4'hF && lad_oe_n_o === 1'b1);
         ok &= (laddr_hi_oe_n_o === 1'b1);
      end
      `CHECK_EQ(ok, 1'b1)
      hold_i = 0;
      for (int n = 0; n < 200 && bus_release_ack_o !== 1'b0; n++) begin
         @(posedge clk_i); #1;
      end
      `CHECK_EQ(bus_release_ack_o, 1'b0)
   endtask : t_hold

   initial begin
      repeat (8) @(posedge clk_i);
      #1;
      srst_i = 0;
      power_on_rc_n_i = 1;
      t_boot;
      t_clk;
      t_ram_read;
      t_io_writes;
      t_sys;
      t_wait;
      t_hold;
      wrap_up;
   end
endmodule : testbench
